/* File: inc/ipe_pkg.sv */
package ipe_pkg;

  typedef enum logic [1:0] {
    IPE_SRC_INVALID = 2'b00,
    IPE_SRC_RECEIVE = 2'b01,
    IPE_SRC_REQ_A   = 2'b10,
    IPE_SRC_REQ_B   = 2'b11
  } ipe_src_t;

  typedef struct packed {
    logic       awRdy;
    logic       awHeld;
    logic [7:0] awAddr;
    logic       wRdy;
    logic       wHeld;
    logic [7:0] wLow;
    logic       wLane0;
    logic       bValid;
    logic [1:0] bResp;
    logic       arRdy;
    logic       rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    ipe_src_t   srcSel;
    logic       firstEn;
    logic       secondEn;
    logic [2:0] txMode;
    logic [2:0] haltCnt;
    logic       txParity;
    logic       txControl;
    logic [7:0] txData;
    logic       firstOe;
    logic       firstParity;
    logic       firstControl;
    logic [7:0] firstData;
    logic       secondOe;
    logic       secondParity;
    logic       secondControl;
    logic [7:0] secondData;
  } ipe_state_t;

endpackage : ipe_pkg

/* File: inc/ipe_regs.svh */
`ifndef IPE_REGS_SVH
`define IPE_REGS_SVH

// Register byte offsets
`define IPE_CFG_OFS       8'h00
`define IPE_MODE_OFS      8'h04
`define IPE_STAT_OFS      8'h08

// Configuration register field positions
`define IPE_SRC_LO_BIT    4
`define IPE_SRC_HI_BIT    5
`define IPE_FIRST_EN_BIT  6
`define IPE_SECOND_EN_BIT 7

// Reset values
`define IPE_SRC_RST       2'h0
`define IPE_FIRST_EN_RST  1'h0
`define IPE_SECOND_EN_RST 1'h0
`define IPE_MODE_RST      3'h1

// Active transmit mode code
`define IPE_MODE_ACTIVE   3'h0

// Symbol pair codes on the transmit path and the Halt run limit
`define IPE_HALT_PAIR     8'h11
`define IPE_IDLE_PAIR     8'hff
`define IPE_HALT_MAX      3'h4

// AXI responses
`define IPE_RESP_OKAY     2'h0
`define IPE_RESP_SLVERR   2'h2

`endif

/* File: logic/ipe_switch.sv */
`timescale 1ns/1ps
`include "ipe_regs.svh"

// What this block does
// RULE1 - Active mode, invalid source: four Halts, then Idle
// RULE2 - First enable low floats first port
// RULE3 - First enable high drives first port
// RULE4 - Second enable low floats second port
// RULE5 - Second enable high drives second port
// RULE6 - Single path: second bit kept, no pin effect
// RULE7 - Two-bit select routes one of four buses
module ipe_switch
  import ipe_pkg::*;
#(
  parameter bit DUAL_PATH = 1'b1
)
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output      logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  input  wire logic        rxParity,
  input  wire logic        rxControl,
  input  wire logic [7:0]  rxData,
  input  wire logic        reqAParity,
  input  wire logic        reqAControl,
  input  wire logic [7:0]  reqAData,
  input  wire logic        reqBParity,
  input  wire logic        reqBControl,
  input  wire logic [7:0]  reqBData,
  output      logic        txParity,
  output      logic        txControl,
  output      logic [7:0]  txData,
  output      logic        firstPortOe,
  output      logic        firstPortParity,
  output      logic        firstPortControl,
  output      logic [7:0]  firstPortData,
  output      logic        secondPortOe,
  output      logic        secondPortParity,
  output      logic        secondPortControl,
  output      logic [7:0]  secondPortData
);

  ipe_state_t st_reg;
  ipe_state_t st_next;
  logic       wrFire;
  logic       haltPath;

  assign wrFire   = st_reg.awHeld && st_reg.wHeld && !st_reg.bValid;
  assign haltPath = (st_reg.txMode == `IPE_MODE_ACTIVE) && (st_reg.srcSel == IPE_SRC_INVALID);

  always_comb
  begin
    st_next = st_reg;

    // Address and data are taken in either order and held until the write commits
    if (s_axi_awvalid && st_reg.awRdy)
    begin
      st_next.awHeld = 1'b1;
      st_next.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wRdy)
    begin
      st_next.wHeld  = 1'b1;
      st_next.wLow   = s_axi_wdata[7:0];
      st_next.wLane0 = s_axi_wstrb[0];
    end
    if (wrFire)
    begin
      st_next.awHeld = 1'b0;
      st_next.wHeld  = 1'b0;
      st_next.bValid = 1'b1;
      st_next.bResp  = `IPE_RESP_OKAY;
      case (st_reg.awAddr)
        `IPE_CFG_OFS:
        begin
          if (st_reg.wLane0)
          begin
            st_next.srcSel   = ipe_src_t'({st_reg.wLow[`IPE_SRC_HI_BIT],
                                           st_reg.wLow[`IPE_SRC_LO_BIT]});
            st_next.firstEn  = st_reg.wLow[`IPE_FIRST_EN_BIT];
            // RULE6 second bit stays writable
            st_next.secondEn = st_reg.wLow[`IPE_SECOND_EN_BIT];
          end
        end
        `IPE_MODE_OFS:
        begin
          if (st_reg.wLane0)
          begin
            st_next.txMode = st_reg.wLow[2:0];
          end
        end
        `IPE_STAT_OFS: st_next.bResp = `IPE_RESP_OKAY;
        default:
        begin
          st_next.bResp = `IPE_RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bValid && s_axi_bready)
    begin
      st_next.bValid = 1'b0;
    end
    // New address or data only once the previous response has gone
    st_next.awRdy = !st_next.awHeld && !st_next.bValid;
    st_next.wRdy  = !st_next.wHeld && !st_next.bValid;

    if (s_axi_arvalid && st_reg.arRdy)
    begin
      st_next.arRdy  = 1'b0;
      st_next.rValid = 1'b1;
      st_next.rResp  = `IPE_RESP_OKAY;
      st_next.rData  = 32'h0;
      case (s_axi_araddr)
        `IPE_CFG_OFS:
        begin
          st_next.rData[`IPE_SRC_HI_BIT:`IPE_SRC_LO_BIT] = st_reg.srcSel;
          st_next.rData[`IPE_FIRST_EN_BIT]  = st_reg.firstEn;
          st_next.rData[`IPE_SECOND_EN_BIT] = st_reg.secondEn;
        end
        `IPE_MODE_OFS:
        begin
          st_next.rData[2:0] = st_reg.txMode;
        end
        `IPE_STAT_OFS:
        begin
          st_next.rData[2:0] = st_reg.haltCnt;
          st_next.rData[3]   = st_reg.firstOe;
          st_next.rData[4]   = st_reg.secondOe;
        end
        default:
        begin
          st_next.rResp = `IPE_RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.rValid && s_axi_rready)
    begin
      st_next.rValid = 1'b0;
      st_next.arRdy  = 1'b1;
    end

    // RULE7 source select
    case (st_reg.srcSel)
      IPE_SRC_RECEIVE:
      begin
        st_next.txParity  = rxParity;
        st_next.txControl = rxControl;
        st_next.txData    = rxData;
      end
      IPE_SRC_REQ_A:
      begin
        st_next.txParity  = reqAParity;
        st_next.txControl = reqAControl;
        st_next.txData    = reqAData;
      end
      IPE_SRC_REQ_B:
      begin
        st_next.txParity  = reqBParity;
        st_next.txControl = reqBControl;
        st_next.txData    = reqBData;
      end
      default:
      begin
        // Invalid bus carries Halt pairs; parity is even over the pair
        st_next.txParity  = ^`IPE_HALT_PAIR;
        st_next.txControl = 1'b1;
        st_next.txData    = `IPE_HALT_PAIR;
      end
    endcase

    // RULE1 repeat filter caps the Halt run, then Idle until the mode or source changes
    if (haltPath)
    begin
      if (st_reg.haltCnt < `IPE_HALT_MAX)
      begin
        st_next.haltCnt = st_reg.haltCnt + 3'h1;
      end
      else
      begin
        st_next.txParity  = ^`IPE_IDLE_PAIR;
        st_next.txControl = 1'b1;
        st_next.txData    = `IPE_IDLE_PAIR;
      end
    end
    else
    begin
      st_next.haltCnt = 3'h0;
    end

    // RULE2 RULE3 first port follows its enable
    st_next.firstOe      = st_reg.firstEn;
    st_next.firstParity  = st_reg.firstEn ? rxParity : 1'b0;
    st_next.firstControl = st_reg.firstEn ? rxControl : 1'b0;
    st_next.firstData    = st_reg.firstEn ? rxData : 8'h00;

    // RULE4 RULE5 RULE6 second port exists only on the dual path part
    st_next.secondOe      = DUAL_PATH && st_reg.secondEn;
    st_next.secondParity  = st_next.secondOe ? rxParity : 1'b0;
    st_next.secondControl = st_next.secondOe ? rxControl : 1'b0;
    st_next.secondData    = st_next.secondOe ? rxData : 8'h00;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_reg          <= '0;
      st_reg.awRdy    <= 1'b1;
      st_reg.wRdy     <= 1'b1;
      st_reg.arRdy    <= 1'b1;
      st_reg.srcSel   <= ipe_src_t'(`IPE_SRC_RST);
      st_reg.firstEn  <= `IPE_FIRST_EN_RST;
      st_reg.secondEn <= `IPE_SECOND_EN_RST;
      st_reg.txMode   <= `IPE_MODE_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready     = st_reg.awRdy;
  assign s_axi_wready      = st_reg.wRdy;
  assign s_axi_bvalid      = st_reg.bValid;
  assign s_axi_bresp       = st_reg.bResp;
  assign s_axi_arready     = st_reg.arRdy;
  assign s_axi_rvalid      = st_reg.rValid;
  assign s_axi_rdata       = st_reg.rData;
  assign s_axi_rresp       = st_reg.rResp;
  assign txParity          = st_reg.txParity;
  assign txControl         = st_reg.txControl;
  assign txData            = st_reg.txData;
  assign firstPortOe       = st_reg.firstOe;
  assign firstPortParity   = st_reg.firstParity;
  assign firstPortControl  = st_reg.firstControl;
  assign firstPortData     = st_reg.firstData;
  assign secondPortOe      = st_reg.secondOe;
  assign secondPortParity  = st_reg.secondParity;
  assign secondPortControl = st_reg.secondControl;
  assign secondPortData    = st_reg.secondData;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_halt_then_idle: assert property ( // RULE1
    haltPath && st_reg.haltCnt == `IPE_HALT_MAX && $stable(st_reg.srcSel)
    |=> txData == `IPE_IDLE_PAIR)
    else $error("Halt run not replaced by Idle");
  a_halt_count_cap: assert property ( // RULE1
    st_reg.haltCnt <= `IPE_HALT_MAX)
    else $error("Halt count above limit");
  a_first_float: assert property ( // RULE2
    !st_reg.firstEn |=> !firstPortOe && firstPortData == 8'h00)
    else $error("First port driven while disabled");

  a_first_drive: assert property ( // RULE3
    st_reg.firstEn |=> firstPortOe && firstPortData == $past(rxData)
                       && firstPortControl == $past(rxControl))
    else $error("First port not driven while enabled");

  a_second_float: assert property ( // RULE4
    !st_reg.secondEn |=> !secondPortOe)
    else $error("Second port driven while disabled");

  a_second_drive: assert property ( // RULE5
    DUAL_PATH && st_reg.secondEn |=> secondPortOe && secondPortData == $past(rxData))
    else $error("Second port not driven while enabled");

  a_second_inert: assert property ( // RULE6
    !DUAL_PATH |-> !secondPortOe && secondPortData == 8'h00)
    else $error("Second port active on single path part");

  a_route_rx: assert property ( // RULE7
    st_reg.srcSel == IPE_SRC_RECEIVE |=> txData == $past(rxData) && txParity == $past(rxParity))
    else $error("Receiver bus not routed");

  a_route_req_b: assert property ( // RULE7
    st_reg.srcSel == IPE_SRC_REQ_B |=> txData == $past(reqBData))
    else $error("Second request bus not routed");

endmodule : ipe_switch

/* File: test/ipe_mac_model.sv */
`timescale 1ns/1ps
module ipe_mac_model
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  output      logic       rxParity,
  output      logic       rxControl,
  output      logic [7:0] rxData,
  output      logic       reqAParity,
  output      logic       reqAControl,
  output      logic [7:0] reqAData,
  output      logic       reqBParity,
  output      logic       reqBControl,
  output      logic [7:0] reqBData
);
  logic [7:0] cnt;
  // Every bus moves each cycle, so a stale copy never passes
  always_ff @(posedge core_clk)
  begin
    if (rst)
      cnt <= 8'h00;
    else
      cnt <= cnt + 8'h35;
  end
  // Even data only, so the receiver bus never looks like a Halt pair
  assign rxData      = {cnt[7:1], 1'b0};
  assign rxControl   = cnt[4];
  assign rxParity    = cnt[1];
  assign reqAData    = ~cnt;
  assign reqAControl = cnt[5];
  assign reqAParity  = cnt[2];
  assign reqBData    = cnt ^ 8'h5a;
  assign reqBControl = cnt[6];
  assign reqBParity  = cnt[3];
endmodule : ipe_mac_model

/* File: test/test_indicate_port_enable_tx_source.sv */
`timescale 1ns/1ps
`include "ipe_regs.svh"
module test_indicate_port_enable_tx_source;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        awV = 1'b0, wV = 1'b0, bRdy = 1'b0, arV = 1'b0, rRdy = 1'b0;
  logic [7:0]  awA = 8'h00, arA = 8'h00;
  logic [31:0] wD = 32'h0, rD;
  logic        awR, wR, bV, arR, rV, txP, txC, aOe, aP, aC, bOe, bP, bC;
  logic        rxP, rxC, qaP, qaC, qbP, qbC;
  logic [1:0]  bRsp, rRsp;
  logic [7:0]  txD, aD, bD, rxD, qaD, qbD;
  logic        sOe, sP, sC;
  logic [7:0]  sD;
  logic [31:0] sRd;
  int          err_total = 0;
  int          n_compared = 0;
  int          haltRun = 0;
  int          lastRun = 0;

  always #50 core_clk = ~core_clk;

  ipe_mac_model mac_u (.core_clk(core_clk), .rst(rst), .rxParity(rxP), .rxControl(rxC),
    .rxData(rxD), .reqAParity(qaP), .reqAControl(qaC), .reqAData(qaD), .reqBParity(qbP),
    .reqBControl(qbC), .reqBData(qbD));

  ipe_switch #(.DUAL_PATH(1'b1)) dut_u (.core_clk(core_clk), .rst(rst),
    .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_awaddr(awA), .s_axi_wvalid(wV),
    .s_axi_wready(wR), .s_axi_wdata(wD), .s_axi_wstrb(4'hf), .s_axi_bvalid(bV),
    .s_axi_bready(bRdy), .s_axi_bresp(bRsp), .s_axi_arvalid(arV), .s_axi_arready(arR),
    .s_axi_araddr(arA), .s_axi_rvalid(rV), .s_axi_rready(rRdy), .s_axi_rdata(rD),
    .s_axi_rresp(rRsp), .rxParity(rxP), .rxControl(rxC), .rxData(rxD), .reqAParity(qaP),
    .reqAControl(qaC), .reqAData(qaD), .reqBParity(qbP), .reqBControl(qbC),
    .reqBData(qbD), .txParity(txP), .txControl(txC), .txData(txD), .firstPortOe(aOe),
    .firstPortParity(aP), .firstPortControl(aC), .firstPortData(aD),
    .secondPortOe(bOe), .secondPortParity(bP), .secondPortControl(bC),
    .secondPortData(bD));

  // Single-path part sees the same traffic; its second port must stay quiet
  ipe_switch #(.DUAL_PATH(1'b0)) dut_single_u (.core_clk(core_clk), .rst(rst),
    .s_axi_awvalid(awV), .s_axi_awready(), .s_axi_awaddr(awA), .s_axi_wvalid(wV),
    .s_axi_wready(), .s_axi_wdata(wD), .s_axi_wstrb(4'hf), .s_axi_bvalid(),
    .s_axi_bready(bRdy), .s_axi_bresp(), .s_axi_arvalid(arV), .s_axi_arready(),
    .s_axi_araddr(arA), .s_axi_rvalid(), .s_axi_rready(rRdy), .s_axi_rdata(sRd),
    .s_axi_rresp(), .rxParity(rxP), .rxControl(rxC), .rxData(rxD), .reqAParity(qaP),
    .reqAControl(qaC), .reqAData(qaD), .reqBParity(qbP), .reqBControl(qbC),
    .reqBData(qbD), .txParity(), .txControl(), .txData(), .firstPortOe(),
    .firstPortParity(), .firstPortControl(), .firstPortData(),
    .secondPortOe(sOe), .secondPortParity(sP), .secondPortControl(sC),
    .secondPortData(sD));

  // Length of the last unbroken run of Halt pairs
  always @(negedge core_clk)
  begin
    if (txD === `IPE_HALT_PAIR)
      haltRun = haltRun + 1;
    else if (haltRun != 0)
    begin
      lastRun = haltRun;
      haltRun = 0;
    end
  end

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awA <= a;
    wD <= d;
    awV <= 1'b1;
    wV <= 1'b1;
    bRdy <= 1'b1;
    while (n < 50)
    begin
      @(posedge core_clk);
      n++;
      if (awR)
        awV <= 1'b0;
      if (wR)
        wV <= 1'b0;
      if (bV)
        break;
    end
    bRdy <= 1'b0;
    cmp(32'(bRsp), 32'(er));
    if (n == 50)
    begin
      err_total++;
      end_sim;
    end
    else
    begin
      // Let one edge pass so the next call never reassigns bready in this step
      @(posedge core_clk);
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    arA <= a;
    arV <= 1'b1;
    rRdy <= 1'b1;
    while (n < 50)
    begin
      @(posedge core_clk);
      n++;
      if (arR)
        arV <= 1'b0;
      if (rV)
        break;
    end
    rRdy <= 1'b0;
    cmp(rD, ed);
    cmp(sRd, ed);
    cmp(32'(rRsp), 32'(er));
    if (n == 50)
    begin
      err_total++;
      end_sim;
    end
    else
    begin
      @(posedge core_clk);
    end
  endtask : axi_rd

  // Outputs at an edge carry the buses as they stood just before it
  task automatic chk_path(input logic [1:0] s, input logic aE, input logic bE);
    logic [9:0] v;
    logic [9:0] r;
    @(negedge core_clk);
    r = {rxP, rxC, rxD};
    v = (s == 2'h1) ? r : (s == 2'h2) ? {qaP, qaC, qaD} : (s == 2'h3) ? {qbP, qbC, qbD}
      : {^`IPE_HALT_PAIR, 1'b1, `IPE_HALT_PAIR};
    @(posedge core_clk);
    @(negedge core_clk);
    cmp(32'({txP, txC, txD}), 32'(v));
    cmp(32'({aOe, aP, aC, aD}), aE ? 32'({1'b1, r}) : 32'h0);
    cmp(32'({bOe, bP, bC, bD}), bE ? 32'({1'b1, r}) : 32'h0);
    cmp(32'({sOe, sP, sC, sD}), 32'h0);
    @(posedge core_clk);
  endtask : chk_path

  task automatic t_reset;
    cmp(32'({aOe, bOe}), 32'h0);
    axi_rd(`IPE_CFG_OFS, 32'h0, `IPE_RESP_OKAY);
    axi_rd(`IPE_MODE_OFS, 32'(`IPE_MODE_RST), `IPE_RESP_OKAY);
    axi_wr(`IPE_CFG_OFS, 32'hffffffff, `IPE_RESP_OKAY);
    axi_rd(`IPE_CFG_OFS, 32'hf0, `IPE_RESP_OKAY);
  endtask : t_reset

  task automatic t_source;
    for (int s = 0; s < 4; s++)
    begin
      axi_wr(`IPE_CFG_OFS, 32'(s * 16 + 192), `IPE_RESP_OKAY);
      chk_path(2'(s), 1'b1, 1'b1);
    end
  endtask : t_source

  task automatic t_ports;
    for (int e = 0; e < 4; e++)
    begin
      axi_wr(`IPE_CFG_OFS, 32'(e * 64 + 16), `IPE_RESP_OKAY);
      chk_path(2'h1, e[0], e[1]);
    end
  endtask : t_ports

  task automatic t_halt;
    axi_wr(`IPE_MODE_OFS, 32'h0, `IPE_RESP_OKAY);
    axi_wr(`IPE_CFG_OFS, 32'h0, `IPE_RESP_OKAY);
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    cmp(32'(lastRun), 32'h4);
    cmp(32'({txC, txD}), 32'({1'b1, `IPE_IDLE_PAIR}));
    @(posedge core_clk);
    axi_wr(`IPE_MODE_OFS, 32'(`IPE_MODE_RST), `IPE_RESP_OKAY);
  endtask : t_halt

  task automatic t_unmapped;
    axi_wr(8'h0c, 32'hffffffff, `IPE_RESP_SLVERR);
    axi_rd(8'h0c, 32'h0, `IPE_RESP_SLVERR);
    axi_rd(`IPE_CFG_OFS, 32'h0, `IPE_RESP_OKAY);
  endtask : t_unmapped

  // Reset in mid-run must float both ports and clear the configuration
  task automatic t_rerun;
    axi_wr(`IPE_CFG_OFS, 32'hd0, `IPE_RESP_OKAY);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    cmp(32'({aOe, bOe, txD}), 32'h0);
    @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    axi_rd(`IPE_CFG_OFS, 32'h0, `IPE_RESP_OKAY);
    chk_path(2'h0, 1'b0, 1'b0);
  endtask : t_rerun

  initial
  begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset;
    t_source;
    t_ports;
    t_halt;
    t_unmapped;
    t_rerun;
    end_sim;
  end
endmodule : test_indicate_port_enable_tx_source
